//--- hdl/ttc_top.v
// trace trigger control: user trace words, breakpoint triggers, buffer select and sync period
`timescale 1ns/1ps
`include "ttc_map.vh"
// Behaviour
// (RULE1) buffer select bit one means trace goes off-chip, zero on-chip.
// (RULE2) read-only sync code gives sync period two to the (code plus five).
// (RULE3) writing user word one or two emits a user type 1 or 2 record.
// (RULE4) software must not write user words in back-to-back cycles.
// (RULE5) user words are 32-bit read/write, reset zero, value sent in the record.
// (RULE6) instruction control bit 29 lets breakpoint matches raise the perf trigger.
// (RULE7) instruction control bit 28 gates breakpoint trace actions.
// (RULE8) each instruction breakpoint has 3-bit action; absent ones read zero.
// (RULE9) data control bit 29 enables perf trigger, bit 28 enables trace actions.
// (RULE10) each data breakpoint has 3-bit action; absent ones read zero.
// (RULE11) action 000 stops tracing if on, else nothing.
// (RULE12) action 001 starts tracing if off, else nothing.
// (RULE13) action 011 starts core and coherence manager tracing if off.
// (RULE14) action 100 while on dumps all perf counters then stops.
// (RULE15) action 101 starts if off and always dumps perf counters.
// (RULE16) action 111 starts core and manager if off, always dumps counters.
// (RULE17) codes 010 and 110 are reserved and do nothing here.
// (RULE18) breakpoint control registers exist only with breakpoints and trace configured.
// (RULE19) third control read-only fields come from the trace control block.
// (RULE20) enabled match performs its action in the cycle it is reported; here trace state and output pulses are registered and change one cycle later.
module ttc_top #(
  parameter HAS_BKPT   = 1,
  parameter NUM_IBKPT  = 4,
  parameter NUM_DBKPT  = 2,
  parameter IBKPT_IMPL = 4'hF,
  parameter DBKPT_IMPL = 2'h3
) (
  // clock and reset
  input  wire        clk_in,
  input  wire        sys_rst_in,
  // coprocessor register access
  input  wire [7:0]  cop_addr_in,
  input  wire        cop_wr_in,
  input  wire [31:0] cop_wdata_in,
  output reg  [31:0] cop_rdata_out,
  // breakpoint matches
  input  wire [3:0]  instr_match_in,
  input  wire [1:0]  data_match_in,
  // values loaded from the trace control block
  input  wire        tcb_load_in,
  input  wire        tcb_buf_sel_in,
  input  wire [2:0]  tcb_sync_code_in,
  input  wire [31:0] tcb_ctl3_in,
  // tracing state
  output wire        trace_on_out,
  output wire        cm_trace_start_out,
  output wire        perf_dump_out,
  output wire        perf_trig_out,
  output wire        trace_buffer_select_out,
  output wire [13:0] sync_period_out,
  // user trace record stream
  output wire        rec_valid_out,
  input  wire        rec_ready_in,
  output wire [1:0]  rec_kind_out,
  output wire [31:0] rec_data_out,
  output wire        rec_overflow_out
);
  localparam ST_OFF = 2'b01;
  localparam ST_ON  = 2'b10;

  reg  [31:0] user_trace_word_one_r;
  reg  [31:0] user_trace_word_two_r;
  reg         trace_buffer_select_r;
  reg  [2:0]  sync_interval_code_r;
  reg  [31:0] third_trace_control_r;
  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg         cm_start_r;
  reg         cm_start_nxt;
  reg         dump_r;
  reg         dump_nxt;
  reg         perf_trig_r;
  reg         overflow_r;
  reg         rec_push;
  reg  [1:0]  rec_kind;
  reg  [31:0] rec_data;
  reg         act_hit;
  reg  [2:0]  act_code;
  wire        wr_word1;
  wire        wr_word2;
  wire        wr_ibkpt;
  wire        wr_dbkpt;
  wire [31:0] ibkpt_reg;
  wire [31:0] dbkpt_reg;
  wire        ibkpt_hit;
  wire        dbkpt_hit;
  wire        ibkpt_perf;
  wire        dbkpt_perf;
  wire [2:0]  ibkpt_act;
  wire [2:0]  dbkpt_act;
  wire        fifo_ready;
  wire [33:0] fifo_out;
  wire        is_on;

  assign wr_word1 = cop_wr_in && (cop_addr_in == `TTC_ADDR_USER_WORD1);
  assign wr_word2 = cop_wr_in && (cop_addr_in == `TTC_ADDR_USER_WORD2);
  assign wr_ibkpt = cop_wr_in && (cop_addr_in == `TTC_ADDR_IBKPT_CTL) && (HAS_BKPT != 0);
  assign wr_dbkpt = cop_wr_in && (cop_addr_in == `TTC_ADDR_DBKPT_CTL) && (HAS_BKPT != 0);

  // user trace words
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      user_trace_word_one_r <= `TTC_USER_RESET; // RULE5
      user_trace_word_two_r <= `TTC_USER_RESET; // RULE5
    end else begin
      if (wr_word1) begin
        user_trace_word_one_r <= cop_wdata_in; // RULE5
      end
      if (wr_word2) begin
        user_trace_word_two_r <= cop_wdata_in; // RULE5
      end
    end
  end

  // record enqueue: one record per user word write
  always @* begin
    rec_push = wr_word1 || wr_word2; // RULE3
    rec_data = cop_wdata_in; // RULE5
    if (wr_word2) begin
      rec_kind = `TTC_REC_USER2; // RULE3
    end else begin
      rec_kind = `TTC_REC_USER1; // RULE3
    end
  end

  // a write with the fifo full loses its record; flag sticks until reset
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      overflow_r <= 1'b0;
    end else if (rec_push && !fifo_ready) begin
      overflow_r <= 1'b1;
    end
  end

  ttc_fifo #(
    .WIDTH (34),
    .DEPTH (16),
    .AW    (4)
  ) u_fifo (
    .clk_in       (clk_in),
    .sys_rst_in   (sys_rst_in),
    .wr_valid_in  (rec_push),
    .wr_ready_out (fifo_ready),
    .wr_data_in   ({rec_kind, rec_data}),
    .rd_valid_out (rec_valid_out),
    .rd_ready_in  (rec_ready_in),
    .rd_data_out  (fifo_out)
  );

  assign rec_kind_out     = fifo_out[33:32];
  assign rec_data_out     = fifo_out[31:0];
  assign rec_overflow_out = overflow_r;

  // fields loaded from the trace control block
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      trace_buffer_select_r <= 1'b0;
      sync_interval_code_r  <= 3'h0;
      third_trace_control_r <= 32'h0000_0000;
    end else if (tcb_load_in) begin
      trace_buffer_select_r <= tcb_buf_sel_in; // RULE1
      sync_interval_code_r  <= tcb_sync_code_in; // RULE2
      third_trace_control_r <= tcb_ctl3_in; // RULE19
    end
  end

  assign trace_buffer_select_out = trace_buffer_select_r; // RULE1
  assign sync_period_out = 14'h0001 << (sync_interval_code_r + `TTC_SYNC_BASE_EXP); // RULE2

  // breakpoint control registers
  ttc_bkpt_ctl #(
    .NUM_BKPT (NUM_IBKPT),
    .IMPL_MSK (IBKPT_IMPL)
  ) u_ibkpt (
    .clk_in        (clk_in),
    .sys_rst_in    (sys_rst_in),
    .wr_en_in      (wr_ibkpt),
    .wr_data_in    (cop_wdata_in),
    .match_in      (instr_match_in),
    .reg_out       (ibkpt_reg),
    .hit_out       (ibkpt_hit),
    .perf_trig_out (ibkpt_perf),
    .action_out    (ibkpt_act)
  );

  ttc_bkpt_ctl #(
    .NUM_BKPT (NUM_DBKPT),
    .IMPL_MSK (DBKPT_IMPL)
  ) u_dbkpt (
    .clk_in        (clk_in),
    .sys_rst_in    (sys_rst_in),
    .wr_en_in      (wr_dbkpt),
    .wr_data_in    (cop_wdata_in),
    .match_in      (data_match_in),
    .reg_out       (dbkpt_reg),
    .hit_out       (dbkpt_hit),
    .perf_trig_out (dbkpt_perf),
    .action_out    (dbkpt_act)
  );

  // instruction breakpoint wins over data breakpoint in the same cycle
  always @* begin
    act_hit  = 1'b0;
    act_code = `TTC_ACT_STOP;
    if (HAS_BKPT != 0) begin // RULE18
      if (ibkpt_hit) begin
        act_hit  = 1'b1; // RULE20
        act_code = ibkpt_act;
      end else if (dbkpt_hit) begin
        act_hit  = 1'b1; // RULE20
        act_code = dbkpt_act;
      end
    end
  end

  assign is_on = (state_r == ST_ON);

  // trace on/off state and action side effects
  // reserved codes fall through to the defaults and leave the state alone
  always @* begin
    state_nxt    = state_r;
    cm_start_nxt = 1'b0;
    dump_nxt     = 1'b0;
    case (state_r)
      ST_OFF: begin
        if (act_hit) begin
          case (act_code)
            `TTC_ACT_START: begin
              state_nxt = ST_ON; // RULE12
            end
            `TTC_ACT_START_CM: begin
              state_nxt    = ST_ON; // RULE13
              cm_start_nxt = 1'b1; // RULE13
            end
            `TTC_ACT_START_DUMP: begin
              state_nxt = ST_ON; // RULE15
              dump_nxt  = 1'b1; // RULE15
            end
            `TTC_ACT_START_CM_DUMP: begin
              state_nxt    = ST_ON; // RULE16
              cm_start_nxt = 1'b1; // RULE16
              dump_nxt     = 1'b1; // RULE16
            end
            default: begin
              state_nxt = ST_OFF; // RULE11 RULE14 RULE17
            end
          endcase
        end
      end
      ST_ON: begin
        if (act_hit) begin
          case (act_code)
            `TTC_ACT_STOP: begin
              state_nxt = ST_OFF; // RULE11
            end
            `TTC_ACT_DUMP_STOP: begin
              state_nxt = ST_OFF; // RULE14
              dump_nxt  = 1'b1; // RULE14
            end
            `TTC_ACT_START_DUMP, `TTC_ACT_START_CM_DUMP: begin
              dump_nxt = 1'b1; // RULE15 RULE16
            end
            default: begin
              state_nxt = ST_ON; // RULE12 RULE13 RULE17
            end
          endcase
        end
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
  end

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_r     <= ST_OFF;
      cm_start_r  <= 1'b0;
      dump_r      <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      cm_start_r  <= cm_start_nxt;
      dump_r      <= dump_nxt;
    end
  end

  // perf trigger pulse follows any enabled match, whatever the action
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      perf_trig_r <= 1'b0;
    end else begin
      perf_trig_r <= (HAS_BKPT != 0) && (ibkpt_perf || dbkpt_perf); // RULE6 RULE9
    end
  end

  assign trace_on_out       = is_on;
  assign cm_trace_start_out = cm_start_r;
  assign perf_dump_out      = dump_r;
  assign perf_trig_out      = perf_trig_r;

  // register read mux; unlisted selects read zero
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      cop_rdata_out <= 32'h0000_0000;
    end else begin
      case (cop_addr_in)
        `TTC_ADDR_USER_WORD1: begin
          cop_rdata_out <= user_trace_word_one_r;
        end
        `TTC_ADDR_USER_WORD2: begin
          cop_rdata_out <= user_trace_word_two_r;
        end
        `TTC_ADDR_TRACE_CTL2: begin
          cop_rdata_out <= {28'h000_0000, trace_buffer_select_r, sync_interval_code_r};
        end
        // breakpoint registers read zero when not configured
        `TTC_ADDR_IBKPT_CTL: begin
          if (HAS_BKPT != 0) begin // RULE18
            cop_rdata_out <= ibkpt_reg;
          end else begin
            cop_rdata_out <= 32'h0000_0000;
          end
        end
        `TTC_ADDR_DBKPT_CTL: begin
          if (HAS_BKPT != 0) begin // RULE18
            cop_rdata_out <= dbkpt_reg;
          end else begin
            cop_rdata_out <= 32'h0000_0000;
          end
        end
        `TTC_ADDR_TRACE_CTL3: begin
          cop_rdata_out <= third_trace_control_r; // RULE19
        end
        default: begin
          cop_rdata_out <= 32'h0000_0000;
        end
      endcase
    end
  end
endmodule // ttc_top

//--- common/ttc_map.vh
// register selects, field positions, reset values and codes of the trace trigger control
`ifndef TTC_MAP_VH
`define TTC_MAP_VH
// coprocessor register/select addresses {reg[4:0], sel[2:0]}
`define TTC_ADDR_TRACE_CTL2   8'hB_A
`define TTC_ADDR_USER_WORD1   8'hB_B
`define TTC_ADDR_USER_WORD2   8'hC_3
`define TTC_ADDR_IBKPT_CTL    8'hB_C
`define TTC_ADDR_DBKPT_CTL    8'hB_D
`define TTC_ADDR_TRACE_CTL3   8'hC_2
// field positions
`define TTC_PERF_EN_BIT       29
`define TTC_TRIG_EN_BIT       28
`define TTC_BUF_SEL_BIT       3
`define TTC_SYNC_HI           2
`define TTC_SYNC_LO           0
`define TTC_SYNC_BASE_EXP     5
// reset values
`define TTC_USER_RESET        32'h0000_0000
`define TTC_BKPT_RESET        32'h0000_0000
// trigger actions
`define TTC_ACT_STOP          3'h0
`define TTC_ACT_START         3'h1
`define TTC_ACT_RSVD0         3'h2
`define TTC_ACT_START_CM      3'h3
`define TTC_ACT_DUMP_STOP     3'h4
`define TTC_ACT_START_DUMP    3'h5
`define TTC_ACT_RSVD1         3'h6
`define TTC_ACT_START_CM_DUMP 3'h7
// trace record kinds
`define TTC_REC_USER1         2'h1
`define TTC_REC_USER2         2'h2
`endif

//--- hdl/ttc_fifo.v
// parameterised valid/ready fifo in flip-flops
`timescale 1ns/1ps
module ttc_fifo #(
  parameter WIDTH = 34,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire             clk_in,
  input  wire             sys_rst_in,
  // fill side
  input  wire             wr_valid_in,
  output wire             wr_ready_out,
  input  wire [WIDTH-1:0] wr_data_in,
  // drain side
  output wire             rd_valid_out,
  input  wire             rd_ready_in,
  output wire [WIDTH-1:0] rd_data_out
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      count_r;
  wire            push;
  wire            pop;

  assign wr_ready_out = (count_r != DEPTH[AW:0]);
  assign rd_valid_out = (count_r != {(AW+1){1'b0}});
  assign rd_data_out  = mem_r[rd_ptr_r];
  assign push         = wr_valid_in && wr_ready_out;
  assign pop          = rd_valid_out && rd_ready_in;

  always @(posedge clk_in) begin
    if (push) begin
      mem_r[wr_ptr_r] <= wr_data_in;
    end
  end

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        count_r <= count_r + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count_r <= count_r - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // ttc_fifo

//--- hdl/ttc_bkpt_ctl.v
// breakpoint trace control register with per-breakpoint action fields
`timescale 1ns/1ps
`include "ttc_map.vh"
module ttc_bkpt_ctl #(
  parameter NUM_BKPT = 4,
  parameter IMPL_MSK = 4'hF
) (
  // clock and reset
  input  wire                  clk_in,
  input  wire                  sys_rst_in,
  // register write
  input  wire                  wr_en_in,
  input  wire [31:0]           wr_data_in,
  // breakpoint matches
  input  wire [NUM_BKPT-1:0]   match_in,
  // register image and decoded trigger
  output wire [31:0]           reg_out,
  output reg                   hit_out,
  output reg                   perf_trig_out,
  output reg  [2:0]            action_out
);
  reg         perf_en_r;
  reg         trig_en_r;
  reg  [2:0]  act_r [0:NUM_BKPT-1];
  wire [31:0] act_flat;
  integer     i;

  genvar g;
  generate
    for (g = 0; g < NUM_BKPT; g = g + 1) begin : g_bkpt
      always @(posedge clk_in) begin
        if (sys_rst_in) begin
          act_r[g] <= 3'h0;
        end else if (wr_en_in && IMPL_MSK[g]) begin
          act_r[g] <= wr_data_in[3*g+2:3*g]; // RULE8 RULE10
        end
      end
      assign act_flat[3*g+2:3*g] = IMPL_MSK[g] ? act_r[g] : 3'h0; // RULE8 RULE10
    end
  endgenerate
  assign act_flat[31:3*NUM_BKPT] = {(32-3*NUM_BKPT){1'b0}};

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      perf_en_r <= 1'b0;
      trig_en_r <= 1'b0;
    end else if (wr_en_in) begin
      perf_en_r <= wr_data_in[`TTC_PERF_EN_BIT];
      trig_en_r <= wr_data_in[`TTC_TRIG_EN_BIT];
    end
  end

  assign reg_out = {2'b00, perf_en_r, trig_en_r, act_flat[27:0]};

  // lowest numbered matching breakpoint wins
  always @* begin
    hit_out       = 1'b0;
    perf_trig_out = 1'b0;
    action_out    = 3'h0;
    for (i = NUM_BKPT - 1; i >= 0; i = i - 1) begin
      if (match_in[i] && IMPL_MSK[i]) begin
        hit_out    = trig_en_r; // RULE7 RULE9
        action_out = act_r[i];
      end
    end
    perf_trig_out = perf_en_r && |(match_in & IMPL_MSK[NUM_BKPT-1:0]); // RULE6 RULE9
  end
endmodule // ttc_bkpt_ctl

//--- bench/ttc_checker.sv
// assertion checker bound to the trace trigger control top
`timescale 1ns/1ps
`include "ttc_map.vh"
module ttc_checker (
  // clock and reset
  input wire        clk_in,
  input wire        sys_rst_in,
  // register access
  input wire [7:0]  cop_addr_in,
  input wire        cop_wr_in,
  input wire [31:0] cop_wdata_in,
  input wire [31:0] cop_rdata_out,
  // triggers and loads
  input wire [3:0]  instr_match_in,
  input wire [1:0]  data_match_in,
  input wire        tcb_load_in,
  input wire        tcb_buf_sel_in,
  input wire [2:0]  tcb_sync_code_in,
  // state and stream
  input wire        trace_on_out,
  input wire        cm_trace_start_out,
  input wire        perf_dump_out,
  input wire        perf_trig_out,
  input wire        trace_buffer_select_out,
  input wire [13:0] sync_period_out,
  input wire        rec_valid_out,
  input wire        rec_ready_in,
  input wire [1:0]  rec_kind_out,
  input wire [31:0] rec_data_out,
  input wire        rec_overflow_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  wire user_wr = cop_wr_in && (cop_addr_in == `TTC_ADDR_USER_WORD1 ||
                               cop_addr_in == `TTC_ADDR_USER_WORD2);
  wire unmapped = !(cop_addr_in inside {`TTC_ADDR_TRACE_CTL2, `TTC_ADDR_USER_WORD1,
    `TTC_ADDR_USER_WORD2, `TTC_ADDR_IBKPT_CTL, `TTC_ADDR_DBKPT_CTL, `TTC_ADDR_TRACE_CTL3});
  property p_unmapped;
    unmapped |=> cop_rdata_out == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_user_rec;
    user_wr && !rec_valid_out |=> rec_valid_out && rec_data_out == $past(cop_wdata_in) &&
      rec_kind_out == (($past(cop_addr_in) == `TTC_ADDR_USER_WORD1) ? 2'h1 : 2'h2);
  endproperty
  a_user_rec: assert property (p_user_rec) else $error("user record wrong");
  property p_buf_sel;
    tcb_load_in |=> trace_buffer_select_out == $past(tcb_buf_sel_in);
  endproperty
  a_buf_sel: assert property (p_buf_sel) else $error("buffer select wrong");
  property p_sync;
    tcb_load_in |=> sync_period_out == (14'h0001 << ($past(tcb_sync_code_in) + 4'd5));
  endproperty
  a_sync: assert property (p_sync) else $error("sync period wrong");
  property p_cm_off;
    cm_trace_start_out |-> trace_on_out && !$past(trace_on_out);
  endproperty
  a_cm_off: assert property (p_cm_off) else $error("manager start while on");
  property p_quiet;
    instr_match_in == 4'h0 && data_match_in == 2'h0 |=> !cm_trace_start_out &&
      !perf_dump_out && !perf_trig_out && $stable(trace_on_out);
  endproperty
  a_quiet: assert property (p_quiet) else $error("action without match");
  property p_dump_stop;
    perf_dump_out && !trace_on_out |-> $past(trace_on_out);
  endproperty
  a_dump_stop: assert property (p_dump_stop) else $error("dump while off");
  property p_hold;
    rec_valid_out && !rec_ready_in |=> rec_valid_out && $stable(rec_data_out) &&
      $stable(rec_kind_out);
  endproperty
  a_hold: assert property (p_hold) else $error("record dropped while stalled");
  c_rec: cover property (rec_valid_out && rec_ready_in);
  c_cm: cover property (cm_trace_start_out);
  c_ovf: cover property ($rose(rec_overflow_out));
endmodule // ttc_checker
bind ttc_top ttc_checker chk_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .cop_addr_in(cop_addr_in), .cop_wr_in(cop_wr_in), .cop_wdata_in(cop_wdata_in),
  .cop_rdata_out(cop_rdata_out), .instr_match_in(instr_match_in),
  .data_match_in(data_match_in), .tcb_load_in(tcb_load_in), .tcb_buf_sel_in(tcb_buf_sel_in),
  .tcb_sync_code_in(tcb_sync_code_in), .trace_on_out(trace_on_out),
  .cm_trace_start_out(cm_trace_start_out), .perf_dump_out(perf_dump_out),
  .perf_trig_out(perf_trig_out), .trace_buffer_select_out(trace_buffer_select_out),
  .sync_period_out(sync_period_out), .rec_valid_out(rec_valid_out),
  .rec_ready_in(rec_ready_in), .rec_kind_out(rec_kind_out), .rec_data_out(rec_data_out),
  .rec_overflow_out(rec_overflow_out));

//--- bench/ttc_sink.sv
// trace record consumer standing in for the trace control block
`timescale 1ns/1ps
module ttc_sink (
  // clock and reset
  input  wire        clk_in,
  input  wire        sys_rst_in,
  // stall request
  input  wire        stall_in,
  // record stream
  input  wire        rec_valid_in,
  input  wire [1:0]  rec_kind_in,
  input  wire [31:0] rec_data_in,
  output wire        rec_ready_out
);
  logic [33:0] q[$];
  assign rec_ready_out = !stall_in && !sys_rst_in;
  always @(posedge clk_in) begin
    if (!sys_rst_in && rec_valid_in === 1'b1 && rec_ready_out)
      q.push_back({rec_kind_in, rec_data_in});
  end
endmodule // ttc_sink

//--- bench/tb_top.sv
// self-checking bench of the trace trigger control
`timescale 1ns/1ps
`include "ttc_map.vh"
module tb_top;
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [7:0]  cop_addr_in = 8'h00;
  logic        cop_wr_in = 1'b0;
  logic [31:0] cop_wdata_in = 32'h0000_0000;
  logic [3:0]  instr_match_in = 4'h0;
  logic [1:0]  data_match_in = 2'h0;
  logic        tcb_load_in = 1'b0;
  logic        tcb_buf_sel_in = 1'b0;
  logic [2:0]  tcb_sync_code_in = 3'h0;
  logic [31:0] tcb_ctl3_in = 32'h0000_0000;
  logic        stall = 1'b0;
  wire  [31:0] cop_rdata_out;
  wire         trace_on_out, cm_trace_start_out, perf_dump_out, perf_trig_out;
  wire         trace_buffer_select_out, rec_valid_out, rec_ready_in, rec_overflow_out;
  wire  [13:0] sync_period_out;
  wire  [1:0]  rec_kind_out;
  wire  [31:0] rec_data_out;
  logic [2:0]  ex;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  always #50 clk_in = ~clk_in;
  ttc_top dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .cop_addr_in(cop_addr_in),
    .cop_wr_in(cop_wr_in), .cop_wdata_in(cop_wdata_in), .cop_rdata_out(cop_rdata_out),
    .instr_match_in(instr_match_in), .data_match_in(data_match_in),
    .tcb_load_in(tcb_load_in), .tcb_buf_sel_in(tcb_buf_sel_in),
    .tcb_sync_code_in(tcb_sync_code_in), .tcb_ctl3_in(tcb_ctl3_in),
    .trace_on_out(trace_on_out), .cm_trace_start_out(cm_trace_start_out),
    .perf_dump_out(perf_dump_out), .perf_trig_out(perf_trig_out),
    .trace_buffer_select_out(trace_buffer_select_out), .sync_period_out(sync_period_out),
    .rec_valid_out(rec_valid_out), .rec_ready_in(rec_ready_in), .rec_kind_out(rec_kind_out),
    .rec_data_out(rec_data_out), .rec_overflow_out(rec_overflow_out));
  ttc_sink sink_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .stall_in(stall),
    .rec_valid_in(rec_valid_out), .rec_kind_in(rec_kind_out), .rec_data_in(rec_data_out),
    .rec_ready_out(rec_ready_in));
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one write, then a cycle with the strobe low so user writes never abut
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_in);
    cop_addr_in = a;
    cop_wdata_in = d;
    cop_wr_in = 1'b1;
    @(negedge clk_in);
    cop_wr_in = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(negedge clk_in);
    cop_addr_in = a;
    @(negedge clk_in);
    chk($sformatf("reg %h", a), e, cop_rdata_out);
  endtask
  task automatic hit(input logic [3:0] i, input logic [1:0] d);
    @(negedge clk_in);
    instr_match_in = i;
    data_match_in = d;
    @(negedge clk_in);
    instr_match_in = 4'h0;
    data_match_in = 2'h0;
  endtask
  // expected {trace on, manager start, counter dump}
  function automatic logic [2:0] act(input logic [2:0] c, input logic s);
    case (c)
      3'h0: act = 3'b000;
      3'h1: act = 3'b100;
      3'h3: act = {1'b1, !s, 1'b0};
      3'h4: act = {1'b0, 1'b0, s};
      3'h5: act = 3'b101;
      3'h7: act = {1'b1, !s, 1'b1};
      default: act = {s, 2'b00};
    endcase
  endfunction
  initial begin
    repeat (20) @(negedge clk_in);
    sys_rst_in = 1'b0;
    rd(`TTC_ADDR_USER_WORD1, 32'h0000_0000);
    rd(`TTC_ADDR_USER_WORD2, 32'h0000_0000);
    rd(`TTC_ADDR_IBKPT_CTL, 32'h0000_0000);
    rd(`TTC_ADDR_DBKPT_CTL, 32'h0000_0000);
    wr(`TTC_ADDR_IBKPT_CTL, 32'hFFFF_FFFF);
    rd(`TTC_ADDR_IBKPT_CTL, 32'h3000_0FFF);
    wr(`TTC_ADDR_DBKPT_CTL, 32'hFFFF_FFFF);
    rd(`TTC_ADDR_DBKPT_CTL, 32'h3000_003F);
    wr(8'h00, 32'hFFFF_FFFF);
    rd(8'h00, 32'h0000_0000);
    for (int c = 0; c < 16; c++) begin
      wr(`TTC_ADDR_IBKPT_CTL, {2'b00, c[0], 1'b1, 22'h0, 2'b00, c[3], c[2:0]});
      hit(4'h2, 2'h0);
      ex = act(c[2:0], c[3]);
      hit(4'h1, 2'h0);
      chk("action", {30'h0, ex, c[0]}, {30'h0, trace_on_out, cm_trace_start_out,
        perf_dump_out, perf_trig_out});
    end
    wr(`TTC_ADDR_IBKPT_CTL, 32'h2000_0000);
    hit(4'h1, 2'h0);
    chk("gated", 34'h1, trace_on_out);
    wr(`TTC_ADDR_DBKPT_CTL, 32'h3000_0005);
    hit(4'h0, 2'h2);
    chk("data bkpt", 34'h1, {trace_on_out, perf_trig_out});
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_in);
      tcb_load_in = 1'b1;
      tcb_buf_sel_in = i[0];
      tcb_sync_code_in = i[2:0];
      tcb_ctl3_in = {8{i[3:0]}};
      @(negedge clk_in);
      tcb_load_in = 1'b0;
      chk("sync", 34'h1 << (i + 5), sync_period_out);
      chk("bufsel", i[0], trace_buffer_select_out);
      rd(`TTC_ADDR_TRACE_CTL2, {28'h0, i[0], i[2:0]});
      rd(`TTC_ADDR_TRACE_CTL3, {8{i[3:0]}});
    end
    wr(`TTC_ADDR_USER_WORD1, 32'hA5A5_0001);
    wr(`TTC_ADDR_USER_WORD2, 32'h5A5A_0002);
    rd(`TTC_ADDR_USER_WORD1, 32'hA5A5_0001);
    rd(`TTC_ADDR_USER_WORD2, 32'h5A5A_0002);
    chk("rec1", {2'h1, 32'hA5A5_0001}, sink_u.q[0]);
    chk("rec2", {2'h2, 32'h5A5A_0002}, sink_u.q[1]);
    sink_u.q.delete();
    stall = 1'b1;
    for (int i = 0; i < 17; i++)
      wr(`TTC_ADDR_USER_WORD1, i);
    chk("overflow", 34'h1, rec_overflow_out);
    rd(`TTC_ADDR_USER_WORD1, 32'h0000_0010);
    stall = 1'b0;
    for (int k = 0; k < 40 && rec_valid_out !== 1'b0; k++)
      @(negedge clk_in);
    chk("drained", 34'd16, sink_u.q.size());
    chk("last", {2'h1, 32'h0000_000F}, sink_u.q[15]);
    end_of_test();
  end
endmodule // tb_top
